// *** src/nirm_pkg.sv ***
// constants for the node identity and config-rom mapping register group
// assumes a 100 MHz system clock and a byte-addressed avalon-mm slave port
package nirm_pkg;

	localparam int AVS_ADDR_W = 6;
	localparam int DATA_W = 32;
	localparam int ID_W = 64;
	localparam int OFFS_W = 48;

	// register byte offsets
	localparam logic [AVS_ADDR_W-1:0] OFF_BUS_OPT = 6'h20;
	localparam logic [AVS_ADDR_W-1:0] OFF_ID_UPPER = 6'h24;
	localparam logic [AVS_ADDR_W-1:0] OFF_ID_LOWER = 6'h28;
	localparam logic [AVS_ADDR_W-1:0] OFF_LOAD_STAT = 6'h30;
	localparam logic [AVS_ADDR_W-1:0] OFF_ROM_MAP = 6'h34;

	// bus-options fields
	localparam int GEN_LSB = 6;
	localparam int GEN_W = 2;
	localparam int SPD_LSB = 0;
	localparam int SPD_W = 3;
	localparam logic [SPD_W-1:0] LINK_SPEED_CODE = 3'h2;

	// mapping register fields
	localparam int MAP_LSB = 10;
	localparam int MAP_W = DATA_W - MAP_LSB;
	localparam logic [DATA_W-1:0] RST_ZERO = 32'h00000000;

	// load status fields
	localparam int STAT_UPPER_LOCK = 0;
	localparam int STAT_LOWER_LOCK = 1;
	localparam int STAT_EE_PRESENT = 2;
	localparam int STAT_EE_BUSY = 3;

	// quadlet-read window of the configuration rom
	localparam logic [OFFS_W-1:0] ROM_WIN_FIRST = 48'hFFFFF0000400;
	localparam logic [OFFS_W-1:0] ROM_WIN_LAST = 48'hFFFFF00007FF;

	// timing
	localparam int CLK_PERIOD_NS = 10;
	localparam int EE_HALF_NS = 1000;
	localparam int EE_HALF_CYC = (EE_HALF_NS + CLK_PERIOD_NS - 1)
		/ CLK_PERIOD_NS;
	localparam int STRAP_SETTLE_NS = 200;
	localparam int STRAP_SETTLE_CYC = (STRAP_SETTLE_NS + CLK_PERIOD_NS - 1)
		/ CLK_PERIOD_NS;
	localparam int CNT_W = 16;

endpackage : nirm_pkg

// *** src/nirm_core_if.sv ***
// signals shared between the register core, the eeprom loader and the
// rom address translator; no clocking, all on sys_clk_i
interface nirm_core_if;
	import nirm_pkg::*;

	logic ld_valid;
	logic [ID_W-1:0] ld_id;
	logic ee_present;
	logic ee_busy;
	logic [DATA_W-1:0] map_base;

	modport loader (output ld_valid, ld_id, ee_present, ee_busy);
	modport regs (input ld_valid, ld_id, ee_present, ee_busy,
		output map_base);
	modport xlate (input map_base);
endinterface : nirm_core_if

// *** src/nirm_ee_loader.sv ***
// serial eeprom reader: after global reset samples the presence strap,
// then clocks 64 identifier bits in msb first and offers them once
// assumes the eeprom shifts data on the falling edge of ee_clk_o
module nirm_ee_loader
	import nirm_pkg::*;
(
	// clock and reset
	input wire logic sys_clk_i,
	input wire logic rst_n_i,
	// eeprom pins
	input wire logic ee_present_i,
	input wire logic ee_data_i,
	output logic ee_clk_o,
	output logic ee_sel_o,
	// core side
	nirm_core_if.loader core
);
	import nirm_pkg::*;

	typedef enum logic [1:0] {LD_SETTLE, LD_SHIFT, LD_DONE} nirm_ld_st_t;

	typedef struct packed {
		nirm_ld_st_t st;
		logic [CNT_W-1:0] cnt;
		logic [6:0] bitn;
		logic [ID_W-1:0] shreg;
		logic [2:0] pres_s;
		logic [2:0] data_s;
		logic pres;
		logic data;
		logic eclk;
		logic sel;
		logic valid;
		logic busy;
	} nirm_ld_t;

	nirm_ld_t r_reg, r_next;

	always_comb begin
		r_next = r_reg;
		r_next.valid = 1'b0;
		r_next.pres_s = {r_reg.pres_s[1:0], ee_present_i};
		r_next.data_s = {r_reg.data_s[1:0], ee_data_i};
		// a pin level counts only once the last two stages agree
		if (r_reg.pres_s[2] == r_reg.pres_s[1]) begin
			r_next.pres = r_reg.pres_s[2];
		end
		if (r_reg.data_s[2] == r_reg.data_s[1]) begin
			r_next.data = r_reg.data_s[2];
		end
		unique case (r_reg.st)
			LD_SETTLE: begin
				r_next.cnt = r_reg.cnt + 1'b1;
				if (r_reg.cnt == CNT_W'(STRAP_SETTLE_CYC)) begin
					r_next.cnt = '0;
					if (r_reg.pres) begin
						r_next.sel = 1'b1;
						r_next.st = LD_SHIFT;
					end else begin
						r_next.busy = 1'b0;
						r_next.st = LD_DONE;
					end
				end
			end
			LD_SHIFT: begin
				r_next.cnt = r_reg.cnt + 1'b1;
				if (r_reg.cnt == CNT_W'(EE_HALF_CYC - 1)) begin
					r_next.cnt = '0;
					r_next.eclk = ~r_reg.eclk;
					// sample at the end of the high half
					if (r_reg.eclk) begin
						r_next.shreg = {r_reg.shreg[ID_W-2:0], r_reg.data};
						r_next.bitn = r_reg.bitn + 1'b1;
						if (r_reg.bitn == 7'(ID_W - 1)) begin
							r_next.valid = 1'b1;
							r_next.sel = 1'b0;
							r_next.busy = 1'b0;
							r_next.st = LD_DONE;
						end
					end
				end
			end
			LD_DONE: begin
				r_next.cnt = '0;
			end
		endcase
	end

	always_ff @(posedge sys_clk_i) begin
		if (!rst_n_i) begin
			r_reg <= '{st: LD_SETTLE, busy: 1'b1, default: '0};
		end else begin
			r_reg <= r_next;
		end
	end

	assign ee_clk_o = r_reg.eclk;
	assign ee_sel_o = r_reg.sel;
	assign core.ld_valid = r_reg.valid;
	assign core.ld_id = r_reg.shreg;
	assign core.ee_present = r_reg.pres;
	assign core.ee_busy = r_reg.busy;

endmodule // nirm_ee_loader

// *** src/nirm_rom_xlate.sv ***
// config-rom window translator: a quadlet read inside the window becomes
// a host memory address one cycle later; anything else reports a miss
module nirm_rom_xlate
	import nirm_pkg::*;
(
	// clock and reset
	input wire logic sys_clk_i,
	input wire logic rst_n_i,
	// incoming read request
	input wire logic req_valid_i,
	input wire logic req_quadlet_i,
	input wire logic [OFFS_W-1:0] req_offset_i,
	// translated address
	output logic map_valid_o,
	output logic map_miss_o,
	output logic [DATA_W-1:0] map_addr_o,
	// mapping base
	nirm_core_if.xlate core
);
	import nirm_pkg::*;

	typedef struct packed {
		logic valid;
		logic miss;
		logic [DATA_W-1:0] addr;
	} nirm_xl_t;

	nirm_xl_t r_reg, r_next;
	logic in_win;

	assign in_win = req_quadlet_i && req_offset_i >= ROM_WIN_FIRST
		&& req_offset_i <= ROM_WIN_LAST;

	always_comb begin
		r_next = r_reg;
		r_next.valid = 1'b0;
		r_next.miss = 1'b0;
		if (req_valid_i) begin
			// base plus low ten offset bits
			if (in_win) begin
				r_next.valid = 1'b1;
				r_next.addr = core.map_base
					+ {{MAP_W{1'b0}}, req_offset_i[MAP_LSB-1:0]};
			end else begin
				r_next.miss = 1'b1;
			end
		end
	end

	always_ff @(posedge sys_clk_i) begin
		if (!rst_n_i) begin
			r_reg <= '0;
		end else begin
			r_reg <= r_next;
		end
	end

	assign map_valid_o = r_reg.valid;
	assign map_miss_o = r_reg.miss;
	assign map_addr_o = r_reg.addr;

	property p_win_addr;
		@(posedge sys_clk_i) disable iff (!rst_n_i)
		(req_valid_i && in_win) |=> map_valid_o && map_addr_o ==
			$past(core.map_base) + {{MAP_W{1'b0}}, $past(req_offset_i[9:0])};
	endproperty
	a_win_addr: assert property (p_win_addr)
		else $error("window read not mapped to base plus offset");

endmodule // nirm_rom_xlate

// *** src/nirm_regs.sv ***
// node identity and config-rom mapping registers behind an avalon-mm slave
// assumes eeprom pins and request inputs as described in the loader and
// translator; the host bus master obeys waitrequest
//
// Notes on behaviour
// - bus-options bits 11..8 always read as zero.
// - bus-options bits 5..3 always read as zero.
// - link-speed field bits 2..0 always reads 010.
// - identifier-upper register shows the top 32 identifier bits.
// - both identifier registers clear to zero on system reset.
// - with an eeprom present, identifier is loaded from it after reset.
// - once loaded, identifier registers ignore any further change.
// - identifier-lower holds low 32 bits, same reset, load and lock.
// - window quadlet reads map to base plus low ten offset bits.
// - mapping register bits 9..0 are read-only zero.
// - mapping register upper field is read/write, resets to zero.
module nirm_regs
	import nirm_pkg::*;
(
	// clock and reset
	input wire logic sys_clk_i,
	input wire logic rst_n_i,
	// avalon-mm slave
	input wire logic [nirm_pkg::AVS_ADDR_W-1:0] avs_address_i,
	input wire logic avs_read_i,
	input wire logic avs_write_i,
	input wire logic [nirm_pkg::DATA_W-1:0] avs_writedata_i,
	input wire logic [3:0] avs_byteenable_i,
	output logic [nirm_pkg::DATA_W-1:0] avs_readdata_o,
	output logic avs_waitrequest_o,
	// serial eeprom
	input wire logic ee_present_i,
	input wire logic ee_data_i,
	output logic ee_clk_o,
	output logic ee_sel_o,
	// config-rom read requests
	input wire logic req_valid_i,
	input wire logic req_quadlet_i,
	input wire logic [nirm_pkg::OFFS_W-1:0] req_offset_i,
	output logic map_valid_o,
	output logic map_miss_o,
	output logic [nirm_pkg::DATA_W-1:0] map_addr_o
);
	import nirm_pkg::*;

	////////////////////////////////////////////////////////////////////////

	typedef struct packed {
		logic wait_n;
		logic [DATA_W-1:0] rdata;
		logic [GEN_W-1:0] gen;
		logic [DATA_W-1:0] id_upper;
		logic [DATA_W-1:0] id_lower;
		logic upper_lock;
		logic lower_lock;
		logic [MAP_W-1:0] map_base;
	} nirm_regs_t;

	nirm_regs_t r_reg, r_next;
	nirm_core_if core ();

	logic acc_take;
	logic wr_take;
	logic id_wr_ok;
	logic [DATA_W-1:0] opt_wr_word;
	logic [DATA_W-1:0] map_wr_word;

	////////////////////////////////////////////////////////////////////////
	// helpers

	function automatic logic [DATA_W-1:0] be_merge(
		input logic [DATA_W-1:0] old_v,
		input logic [DATA_W-1:0] new_v,
		input logic [3:0] be
	);
		logic [DATA_W-1:0] res;
		res = old_v;
		for (int i = 0; i < 4; i++) begin
			if (be[i]) begin
				res[8*i +: 8] = new_v[8*i +: 8];
			end
		end
		return res;
	endfunction

	function automatic logic [DATA_W-1:0] bus_opt_word(
		input logic [GEN_W-1:0] gen
	);
		logic [DATA_W-1:0] w;
		w = RST_ZERO;
		w[GEN_LSB +: GEN_W] = gen;
		w[SPD_LSB +: SPD_W] = LINK_SPEED_CODE;
		return w;
	endfunction

	////////////////////////////////////////////////////////////////////////
	// sub-blocks

	nirm_ee_loader u_loader (
		.sys_clk_i(sys_clk_i),
		.rst_n_i(rst_n_i),
		.ee_present_i(ee_present_i),
		.ee_data_i(ee_data_i),
		.ee_clk_o(ee_clk_o),
		.ee_sel_o(ee_sel_o),
		.core(core.loader)
	);

	nirm_rom_xlate u_xlate (
		.sys_clk_i(sys_clk_i),
		.rst_n_i(rst_n_i),
		.req_valid_i(req_valid_i),
		.req_quadlet_i(req_quadlet_i),
		.req_offset_i(req_offset_i),
		.map_valid_o(map_valid_o),
		.map_miss_o(map_miss_o),
		.map_addr_o(map_addr_o),
		.core(core.xlate)
	);

	assign core.map_base = {r_reg.map_base, {MAP_LSB{1'b0}}};

	////////////////////////////////////////////////////////////////////////
	// bus handshake: one wait cycle, then answer

	// a request seen with waitrequest high earns one low cycle next
	assign acc_take = (avs_read_i || avs_write_i) && r_reg.wait_n;
	// a write lands only on the edge where waitrequest is sampled low
	assign wr_take = avs_write_i && !r_reg.wait_n;
	// bios may load only when no eeprom owns the identifier
	assign id_wr_ok = !core.ee_busy && !core.ee_present;
	// byte-merged write words, sliced into the field registers below
	assign opt_wr_word = be_merge(bus_opt_word(r_reg.gen), avs_writedata_i,
		avs_byteenable_i);
	assign map_wr_word = be_merge(core.map_base, avs_writedata_i,
		avs_byteenable_i);

	always_comb begin
		r_next = r_reg;
		r_next.wait_n = 1'b1;
		if (acc_take) begin
			r_next.wait_n = 1'b0;
			unique case (avs_address_i)
				OFF_BUS_OPT: r_next.rdata = bus_opt_word(r_reg.gen);
				OFF_ID_UPPER: r_next.rdata = r_reg.id_upper;
				OFF_ID_LOWER: r_next.rdata = r_reg.id_lower;
				OFF_LOAD_STAT: begin
					r_next.rdata = RST_ZERO;
					r_next.rdata[STAT_UPPER_LOCK] = r_reg.upper_lock;
					r_next.rdata[STAT_LOWER_LOCK] = r_reg.lower_lock;
					r_next.rdata[STAT_EE_PRESENT] = core.ee_present;
					r_next.rdata[STAT_EE_BUSY] = core.ee_busy;
				end
				// low ten bits read as zero
				OFF_ROM_MAP: r_next.rdata = core.map_base;
				default: r_next.rdata = RST_ZERO;
			endcase
		end
		if (wr_take) begin
			unique case (avs_address_i)
				OFF_BUS_OPT: begin
					// only the two-bit field takes the write
					r_next.gen = opt_wr_word[GEN_LSB +: GEN_W];
				end
				OFF_ID_UPPER: begin
					if (!r_reg.upper_lock && id_wr_ok) begin
						r_next.id_upper = be_merge(r_reg.id_upper,
							avs_writedata_i, avs_byteenable_i);
						r_next.upper_lock = 1'b1;
					end
				end
				OFF_ID_LOWER: begin
					// same single load as the upper word
					if (!r_reg.lower_lock && id_wr_ok) begin
						r_next.id_lower = be_merge(r_reg.id_lower,
							avs_writedata_i, avs_byteenable_i);
						r_next.lower_lock = 1'b1;
					end
				end
				OFF_ROM_MAP: begin
					r_next.map_base = map_wr_word[DATA_W-1:MAP_LSB];
				end
				default: begin
				end
			endcase
		end
		if (core.ld_valid) begin
			if (!r_reg.upper_lock) begin
				r_next.id_upper = core.ld_id[ID_W-1:DATA_W];
				r_next.upper_lock = 1'b1;
			end
			if (!r_reg.lower_lock) begin
				r_next.id_lower = core.ld_id[DATA_W-1:0];
				r_next.lower_lock = 1'b1;
			end
		end
	end

	always_ff @(posedge sys_clk_i) begin
		if (!rst_n_i) begin
			r_reg <= '{wait_n: 1'b1, default: '0};
		end else begin
			r_reg <= r_next;
		end
	end

	assign avs_readdata_o = r_reg.rdata;
	assign avs_waitrequest_o = r_reg.wait_n;

	////////////////////////////////////////////////////////////////////////
	// checks

	property p_opt_hi_zero;
		@(posedge sys_clk_i) disable iff (!rst_n_i)
		(avs_read_i && r_reg.wait_n && avs_address_i == OFF_BUS_OPT)
			|=> !avs_waitrequest_o && avs_readdata_o[11:8] == 4'h0;
	endproperty
	a_opt_hi_zero: assert property (p_opt_hi_zero)
		else $error("bus-options bits 11..8 not zero");

	property p_opt_mid_zero;
		@(posedge sys_clk_i) disable iff (!rst_n_i)
		(avs_read_i && r_reg.wait_n && avs_address_i == OFF_BUS_OPT)
			|=> avs_readdata_o[5:3] == 3'h0
			&& avs_readdata_o[7:6] == $past(r_reg.gen);
	endproperty
	a_opt_mid_zero: assert property (p_opt_mid_zero)
		else $error("bus-options bits 5..3 not zero");

	property p_speed;
		@(posedge sys_clk_i) disable iff (!rst_n_i)
		(avs_read_i && r_reg.wait_n && avs_address_i == OFF_BUS_OPT)
			|=> avs_readdata_o[2:0] == 3'h2;
	endproperty
	a_speed: assert property (p_speed)
		else $error("link-speed field not 010");

	property p_upper_read;
		@(posedge sys_clk_i) disable iff (!rst_n_i)
		(avs_read_i && r_reg.wait_n && avs_address_i == OFF_ID_UPPER)
			|=> avs_readdata_o == $past(r_reg.id_upper);
	endproperty
	a_upper_read: assert property (p_upper_read)
		else $error("identifier-upper read mismatch");

	property p_id_reset;
		@(posedge sys_clk_i) disable iff (!rst_n_i)
		$rose(rst_n_i) |-> r_reg.id_upper == RST_ZERO
			&& r_reg.id_lower == RST_ZERO && !r_reg.upper_lock;
	endproperty
	a_id_reset: assert property (p_id_reset)
		else $error("identifier not cleared by reset");

	property p_ee_load;
		@(posedge sys_clk_i) disable iff (!rst_n_i)
		(core.ld_valid && !r_reg.upper_lock) |=>
			r_reg.id_upper == $past(core.ld_id[63:32]) && r_reg.upper_lock;
	endproperty
	a_ee_load: assert property (p_ee_load)
		else $error("eeprom image not loaded");

	property p_upper_lock;
		@(posedge sys_clk_i) disable iff (!rst_n_i)
		r_reg.upper_lock |=> r_reg.upper_lock && $stable(r_reg.id_upper);
	endproperty
	a_upper_lock: assert property (p_upper_lock)
		else $error("locked identifier-upper changed");

	property p_lower_lock;
		@(posedge sys_clk_i) disable iff (!rst_n_i)
		r_reg.lower_lock |=> r_reg.lower_lock && $stable(r_reg.id_lower);
	endproperty
	a_lower_lock: assert property (p_lower_lock)
		else $error("locked identifier-lower changed");

	property p_map_low_zero;
		@(posedge sys_clk_i) disable iff (!rst_n_i)
		(avs_read_i && r_reg.wait_n && avs_address_i == OFF_ROM_MAP)
			|=> avs_readdata_o[9:0] == 10'h000;
	endproperty
	a_map_low_zero: assert property (p_map_low_zero)
		else $error("mapping bits 9..0 not zero");

	property p_map_write;
		@(posedge sys_clk_i) disable iff (!rst_n_i)
		(wr_take && avs_address_i == OFF_ROM_MAP
			&& avs_byteenable_i == 4'hF)
			|=> r_reg.map_base == $past(avs_writedata_i[31:10]);
	endproperty
	a_map_write: assert property (p_map_write)
		else $error("mapping write not stored");

	property p_lower_read;
		@(posedge sys_clk_i) disable iff (!rst_n_i)
		(avs_read_i && r_reg.wait_n && avs_address_i == OFF_ID_LOWER)
			|=> avs_readdata_o == $past(r_reg.id_lower);
	endproperty
	a_lower_read: assert property (p_lower_read)
		else $error("identifier-lower read mismatch");

	property p_ee_load_lower;
		@(posedge sys_clk_i) disable iff (!rst_n_i)
		(core.ld_valid && !r_reg.lower_lock) |=>
			r_reg.id_lower == $past(core.ld_id[31:0]) && r_reg.lower_lock;
	endproperty
	a_ee_load_lower: assert property (p_ee_load_lower)
		else $error("eeprom image not loaded into lower word");

	property p_id_refused;
		@(posedge sys_clk_i) disable iff (!rst_n_i)
		(wr_take && avs_address_i == OFF_ID_UPPER && !id_wr_ok
			&& !core.ld_valid) |=> $stable(r_reg.id_upper);
	endproperty
	a_id_refused: assert property (p_id_refused)
		else $error("identifier-upper written while eeprom owns it");

	property p_bios_load;
		@(posedge sys_clk_i) disable iff (!rst_n_i)
		(wr_take && avs_address_i == OFF_ID_UPPER && !r_reg.upper_lock
			&& id_wr_ok && avs_byteenable_i == 4'hF)
			|=> r_reg.upper_lock
			&& r_reg.id_upper == $past(avs_writedata_i);
	endproperty
	a_bios_load: assert property (p_bios_load)
		else $error("bios identifier load not taken and locked");

	property p_map_read;
		@(posedge sys_clk_i) disable iff (!rst_n_i)
		(avs_read_i && r_reg.wait_n && avs_address_i == OFF_ROM_MAP)
			|=> avs_readdata_o[31:10] == $past(r_reg.map_base);
	endproperty
	a_map_read: assert property (p_map_read)
		else $error("mapping read mismatch");

	property p_map_reset;
		@(posedge sys_clk_i) disable iff (!rst_n_i)
		$rose(rst_n_i) |-> r_reg.map_base == '0 && r_reg.gen == '0;
	endproperty
	a_map_reset: assert property (p_map_reset)
		else $error("mapping register not cleared by reset");

endmodule // nirm_regs

// *** verification/nirm_ee_model.sv ***
// behavioural serial eeprom holding one 64-bit identifier
// assumes select stays high for a whole read and the clock idles low
module nirm_ee_model #(
	// arbitrary test pattern, not any real maker or part code
	parameter logic [63:0] STORED_ID = 64'hC3A51E0F96D24B78
) (
	// eeprom pins
	input wire logic ee_clk_i,
	input wire logic ee_sel_i,
	output logic ee_data_o
);
	timeunit 1ns;
	timeprecision 1ps;

	int bit_idx;

	initial begin
		ee_data_o = 1'b0;
		bit_idx = -1;
	end

	////////////////////////////////////////////////////////////////////////
	// msb first shift
	always @(posedge ee_sel_i) begin
		bit_idx = 63;
		ee_data_o = STORED_ID[63];
	end

	// next bit goes out on the fall, giving a full low and high half of setup
	always @(negedge ee_clk_i) begin
		if (ee_sel_i && bit_idx > 0) begin
			bit_idx = bit_idx - 1;
			ee_data_o = STORED_ID[bit_idx];
		end else if (bit_idx == 0) begin
			bit_idx = -1;
			ee_data_o = ~ee_data_o;
		end
	end

	// released line must not keep showing the last bit
	always @(negedge ee_sel_i) begin
		if (bit_idx == 0) begin
			bit_idx = -1;
			ee_data_o = ~ee_data_o;
		end
	end
endmodule // nirm_ee_model

// *** verification/nirm_regs_test.sv ***
// self-checking bench for the node identity and rom mapping registers
// assumes the avalon slave answers by waitrequest and the eeprom model
module nirm_regs_test;
	timeunit 1ns;
	timeprecision 1ps;
	import nirm_pkg::*;

	localparam logic [63:0] EE_ID = 64'hC3A51E0F96D24B78;

	logic sys_clk_i, rst_n_i, avs_read_i, avs_write_i, ee_present_i;
	logic [AVS_ADDR_W-1:0] avs_address_i;
	logic [DATA_W-1:0] avs_writedata_i, avs_readdata_o, map_addr_o;
	logic [3:0] avs_byteenable_i;
	logic avs_waitrequest_o, ee_data_i, ee_clk_o, ee_sel_o;
	logic req_valid_i, req_quadlet_i, map_valid_o, map_miss_o;
	logic [OFFS_W-1:0] req_offset_i;
	int err_total, cmp_count;
	int ee_rises = 0;
	logic [DATA_W-1:0] exp_addr;
	logic [OFFS_W-1:0] offs [6];
	logic quad [6];
	logic hit [6];

	nirm_regs dut (.sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i),
		.avs_address_i(avs_address_i), .avs_read_i(avs_read_i),
		.avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i),
		.avs_byteenable_i(avs_byteenable_i),
		.avs_readdata_o(avs_readdata_o),
		.avs_waitrequest_o(avs_waitrequest_o),
		.ee_present_i(ee_present_i), .ee_data_i(ee_data_i),
		.ee_clk_o(ee_clk_o), .ee_sel_o(ee_sel_o),
		.req_valid_i(req_valid_i), .req_quadlet_i(req_quadlet_i),
		.req_offset_i(req_offset_i), .map_valid_o(map_valid_o),
		.map_miss_o(map_miss_o), .map_addr_o(map_addr_o));

	nirm_ee_model #(.STORED_ID(EE_ID)) eeprom (.ee_clk_i(ee_clk_o),
		.ee_sel_i(ee_sel_o), .ee_data_o(ee_data_i));

	initial begin
		sys_clk_i = 1'b0;
		forever #5 sys_clk_i = ~sys_clk_i;
	end

	// serial clock pulses seen on the eeprom pin over the whole run
	always @(posedge ee_clk_o) begin
		ee_rises++;
	end

	////////////////////////////////////////////////////////////////////////
	task automatic complete_run();
		$display("comparisons %0d mismatches %0d", cmp_count, err_total);
		if (err_total == 0 && cmp_count > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask

	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp) begin
			$display("wrong value at %0t ns: got %h expected %h",
				$time, got, exp);
			err_total++;
		end
	endtask

	// one avalon access, held until waitrequest is seen low at an edge
	task automatic bus(input logic wr, input logic [AVS_ADDR_W-1:0] a,
		input logic [31:0] wd, output logic [31:0] rd);
		int n;
		@(posedge sys_clk_i);
		avs_address_i <= a;
		avs_writedata_i <= wd;
		avs_read_i <= ~wr;
		avs_write_i <= wr;
		for (n = 0; n < 50; n++) begin
			@(posedge sys_clk_i);
			if (avs_waitrequest_o === 1'b0) begin
				break;
			end
		end
		rd = avs_readdata_o;
		avs_read_i <= 1'b0;
		avs_write_i <= 1'b0;
		if (n == 50) begin
			err_total++;
			complete_run();
		end
	endtask

	task automatic wr(input logic [AVS_ADDR_W-1:0] a, input logic [31:0] d);
		logic [31:0] dummy;
		bus(1'b1, a, d, dummy);
	endtask

	task automatic rd_chk(input logic [AVS_ADDR_W-1:0] a,
		input logic [31:0] exp);
		logic [31:0] got;
		bus(1'b0, a, 32'h00000000, got);
		check(got, exp);
	endtask

	// poll load status until the loader reports idle
	task automatic wait_idle();
		int n;
		logic [31:0] st;
		for (n = 0; n < 8000; n++) begin
			bus(1'b0, OFF_LOAD_STAT, 32'h00000000, st);
			if (st[STAT_EE_BUSY] === 1'b0) begin
				break;
			end
		end
		if (n == 8000) begin
			err_total++;
			complete_run();
		end
	endtask

	task automatic do_reset(input logic present);
		@(posedge sys_clk_i);
		rst_n_i <= 1'b0;
		ee_present_i <= present;
		repeat (4) @(posedge sys_clk_i);
		rst_n_i <= 1'b1;
	endtask

	////////////////////////////////////////////////////////////////////////
	initial begin
		err_total = 0;
		cmp_count = 0;
		rst_n_i = 1'b0;
		avs_read_i = 1'b0;
		avs_write_i = 1'b0;
		avs_address_i = 6'h00;
		avs_writedata_i = 32'h00000000;
		avs_byteenable_i = 4'hF;
		ee_present_i = 1'b0;
		req_valid_i = 1'b0;
		req_quadlet_i = 1'b0;
		req_offset_i = 48'h000000000000;
		offs = '{48'hFFFFF0000400, 48'hFFFFF00007FF, 48'hFFFFF0000800,
			48'hFFFFF00003FC, 48'hFFFFF0000404, 48'hFFFFF0000558};
		quad = '{1'b1, 1'b1, 1'b1, 1'b1, 1'b0, 1'b1};
		hit = '{1'b1, 1'b1, 1'b0, 1'b0, 1'b0, 1'b1};
		do_reset(1'b0);
		rd_chk(OFF_ID_UPPER, 32'h00000000);
		rd_chk(OFF_ID_LOWER, 32'h00000000);
		rd_chk(OFF_ROM_MAP, 32'h00000000);
		wait_idle();
		rd_chk(OFF_LOAD_STAT, 32'h00000000);
		check(ee_rises, 32'h00000000);
		rd_chk(OFF_BUS_OPT, {29'h0, LINK_SPEED_CODE});
		wr(OFF_BUS_OPT, 32'hFFFFFFFF);
		rd_chk(OFF_BUS_OPT, {24'h0, 2'h3, 3'h0, LINK_SPEED_CODE});
		wr(OFF_BUS_OPT, 32'h00000000);
		rd_chk(OFF_BUS_OPT, {29'h0, LINK_SPEED_CODE});
		wr(OFF_BUS_OPT, 32'hFFFFF0BA);
		rd_chk(OFF_BUS_OPT, {24'h0, 2'h2, 3'h0, LINK_SPEED_CODE});
		wr(OFF_ROM_MAP, 32'hFFFFFFFF);
		rd_chk(OFF_ROM_MAP, 32'hFFFFFC00);
		wr(6'h3C, 32'h5A5A5A5A);
		rd_chk(6'h3C, 32'h00000000);
		// bios load, then a second attempt that must not stick
		wr(OFF_ID_UPPER, 32'h12345678);
		wr(OFF_ID_LOWER, 32'h9ABCDEF0);
		wr(OFF_ID_UPPER, 32'hAAAAAAAA);
		wr(OFF_ID_LOWER, 32'h55555555);
		rd_chk(OFF_ID_UPPER, 32'h12345678);
		rd_chk(OFF_ID_LOWER, 32'h9ABCDEF0);
		rd_chk(OFF_LOAD_STAT, 32'h00000003);
		// back-to-back window requests, each result seen one edge later
		wr(OFF_ROM_MAP, 32'h89ABCDEF);
		rd_chk(OFF_ROM_MAP, 32'h89ABCC00);
		exp_addr = 32'h00000000;
		for (int i = 0; i <= 6; i++) begin
			@(posedge sys_clk_i);
			req_valid_i <= (i < 6);
			req_quadlet_i <= (i < 6) ? quad[i] : 1'b0;
			req_offset_i <= (i < 6) ? offs[i] : 48'h000000000000;
			#1;
			if (i > 0) begin
				if (hit[i-1]) begin
					exp_addr = 32'h89ABCC00 + {22'h0, offs[i-1][9:0]};
				end
				check({31'h0, map_valid_o}, {31'h0, hit[i-1]});
				check({31'h0, map_miss_o}, {31'h0, ~hit[i-1]});
				if (exp_addr != 32'h00000000) begin
					check(map_addr_o, exp_addr);
				end
			end
		end
		// eeprom present: identifiers clear, refuse bus, then load and lock
		do_reset(1'b1);
		rd_chk(OFF_ID_UPPER, 32'h00000000);
		rd_chk(OFF_ROM_MAP, 32'h00000000);
		rd_chk(OFF_BUS_OPT, {29'h0, LINK_SPEED_CODE});
		wr(OFF_ID_UPPER, 32'h11111111);
		rd_chk(OFF_ID_LOWER, 32'h00000000);
		wait_idle();
		rd_chk(OFF_ID_UPPER, EE_ID[63:32]);
		rd_chk(OFF_ID_LOWER, EE_ID[31:0]);
		wr(OFF_ID_UPPER, 32'h0F0F0F0F);
		wr(OFF_ID_LOWER, 32'hF0F0F0F0);
		rd_chk(OFF_ID_UPPER, EE_ID[63:32]);
		rd_chk(OFF_ID_LOWER, EE_ID[31:0]);
		rd_chk(OFF_LOAD_STAT, 32'h00000007);
		check(ee_rises, 32'h00000040);
		check({30'h0, ee_sel_o, ee_clk_o}, 32'h00000000);
		complete_run();
	end
endmodule // nirm_regs_test
